// ### hdl/sdpi_pkg.sv
// Shared constants and types of the DRAM control and data pin interface
package sdpi_pkg;
    // ----------------------------------------------------------------
    // Array and bus geometry
    // ----------------------------------------------------------------
    localparam int NBANK = 8;
    localparam int BA_W = 3;
    localparam int ADDR_W = 14;
    localparam int LANE_W = 8;
    localparam int X16 = 16;
    localparam int X8 = 8;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int AUTO_PRE_POS = 10;
    localparam int TERM_EN_POS = 2;
    localparam logic [2:0] EMR_SEL = 3'h1;
    localparam logic TERM_EN_RST = 1'h1;
    // ----------------------------------------------------------------
    // Commands as {row strobe, column strobe, write strobe}, active low
    // ----------------------------------------------------------------
    localparam logic [2:0] CMD_LMR = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    // ----------------------------------------------------------------
    // Power states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_ACT = 4'h1,
        ST_PPD = 4'h2,
        ST_APD = 4'h4,
        ST_SR = 4'h8
    } sdpi_pwr_t;
endpackage : sdpi_pkg

// ### hdl/sdpi_top.sv
// Device-side control and data pin interface: capture, power states, masking, termination
//
// Overview of operation
// - Address and control pins are captured on the rising true clock edge.
// - Read data and strobe outputs are launched from the link clock.
// - Registered clock enable high runs internal clocking; low stops it per state.
// - Clock enable low: idle banks give precharge power-down or self refresh, open give active.
// - Power-down entry, exit and self-refresh entry use clock enable sampled on the clock.
// - Self-refresh exit is detected on the core clock, independent of the link clock.
// - Power-down keeps clock, enable, termination buffers; self refresh keeps only enable.
// - Commands act only with rank select registered low; otherwise masked.
// - Command decoded from rank select, row, column and write strobes together.
// - A write beat with its mask high leaves the stored lane unchanged.
// - Mask is sampled for both the rising and the falling data beat.
// - In sixteen-bit mode the low and high masks gate their bytes independently.
// - Termination control registered high enables internal termination.
// - Termination reaches only data, strobe and mask pins of the width in use.
// - Termination control is ignored while termination is disabled by mode load.
// - Data bus is sixteen, eight or four bits wide per organisation.
// - Device drives the strobe edge-aligned with read data; controller centres it on writes.
// - Precharge closes the addressed bank, or all banks with the auto precharge bit.
`timescale 1ns/1ps
`default_nettype none
module sdpi_top
    import sdpi_pkg::*;
#(
    parameter int DQ_W = 16,
    parameter int DEPTH = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sys_clk_true,
    input wire logic sys_clk_comp,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [BA_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic term_ctrl,
    input wire logic [DQ_W-1:0] dq_in_rise,
    input wire logic [DQ_W-1:0] dq_in_fall,
    input wire logic low_byte_wmask_rise,
    input wire logic low_byte_wmask_fall,
    input wire logic up_byte_wmask_rise,
    input wire logic up_byte_wmask_fall,
    output logic [DQ_W-1:0] dq_out_rise,
    output logic [DQ_W-1:0] dq_out_fall,
    output logic dq_oe,
    output logic strobe_out_rise,
    output logic strobe_out_fall,
    output logic strobe_oe,
    output logic redundant_strobe_oe,
    output logic int_clk_en,
    output logic ibuf_main_en,
    output logic ibuf_clkterm_en,
    output logic [DQ_W-1:0] term_dq,
    output logic term_strobe,
    output logic term_mask,
    output logic term_rstrobe,
    output logic [3:0] pwr_state,
    output logic [NBANK-1:0] banks_open,
    output logic cmd_taken,
    output logic pair_fault,
    output logic core_self_ref
);
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int NL = (DQ_W == X16) ? 2 : 1;
    localparam int LW = (DQ_W == X16) ? LANE_W : DQ_W;
    localparam int IDX_W = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // Link domain state
    // ----------------------------------------------------------------
    sdpi_pwr_t st_q, st_d;
    logic cke_q, cke_d, cs_n_q, cs_n_d, ras_q, ras_d, cas_q, cas_d, we_q, we_d;
    logic [BA_W-1:0] ba_q, ba_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic term_q, term_d, emr_term_q, emr_term_d;
    logic [DQ_W-1:0] din_r_q, din_r_d, din_f_q, din_f_d;
    logic [1:0] mr_q, mr_d, mf_q, mf_d;
    logic [NBANK-1:0] banks_q, banks_d;
    logic [2*DQ_W-1:0] mem_q [DEPTH];
    logic [2*DQ_W-1:0] mem_d [DEPTH];
    logic wr_pend_q, wr_pend_d;
    logic [IDX_W-1:0] wr_idx_q, wr_idx_d;
    logic [DQ_W-1:0] dqr_q, dqr_d, dqf_q, dqf_d;
    logic dq_oe_q, dq_oe_d, stb_q, stb_d, rstb_q, rstb_d;
    logic clk_en_q, clk_en_d, ib_main_q, ib_main_d, ib_ct_q, ib_ct_d;
    logic term_on_q, term_on_d, taken_q, taken_d, sr_flag_q, sr_flag_d;
    logic comp_s1_q, comp_s2_q, x_s1_q, x_s2_q, x_s3_q;
    logic [2:0] cmd;
    logic exec, sr_exit;
    logic [DQ_W-1:0] w_r, w_f;

    // ----------------------------------------------------------------
    // Core domain state
    // ----------------------------------------------------------------
    logic cke_s1_q, cke_s2_q, sr_s1_q, sr_s2_q;
    logic pend_q, pend_d, tgl_q, tgl_d;

    assign cmd = {ras_q, cas_q, we_q};
    assign exec = (st_q == ST_ACT) && cke_q && !cs_n_q;
    assign sr_exit = x_s2_q != x_s3_q;

    // ----------------------------------------------------------------
    // Link next state
    // ----------------------------------------------------------------
    always_comb
    begin
        // Pins captured every rising true edge; masked buffers read as idle
        cke_d = cke;
        cs_n_d = (st_q == ST_ACT) ? cs_n : 1'h1;
        ras_d = ras_n;
        cas_d = cas_n;
        we_d = we_n;
        ba_d = ba;
        addr_d = addr;
        term_d = (st_q == ST_SR) ? 1'h0 : term_ctrl;
        din_r_d = dq_in_rise;
        din_f_d = dq_in_fall;
        mr_d = {up_byte_wmask_rise, low_byte_wmask_rise};
        mf_d = {up_byte_wmask_fall, low_byte_wmask_fall};
        st_d = st_q;
        banks_d = banks_q;
        emr_term_d = emr_term_q;
        mem_d = mem_q;
        wr_pend_d = 1'h0;
        wr_idx_d = wr_idx_q;
        dqr_d = dqr_q;
        dqf_d = dqf_q;
        dq_oe_d = 1'h0;
        stb_d = 1'h0;
        rstb_d = 1'h0;
        taken_d = 1'h0;
        w_r = mem_q[wr_idx_q][DQ_W-1:0];
        w_f = mem_q[wr_idx_q][2*DQ_W-1:DQ_W];
        if (wr_pend_q)
        begin
            for (int l = 0; l < NL; l++)
            begin
                if (!mr_q[l])
                    w_r[l*LW +: LW] = din_r_q[l*LW +: LW];
                if (!mf_q[l])
                    w_f[l*LW +: LW] = din_f_q[l*LW +: LW];
            end
            mem_d[wr_idx_q] = {w_f, w_r};
        end
        case (st_q)
            ST_ACT:
            begin
                if (!cke_q)
                begin
                    // Entry decided on the sampled enable, never on the raw pin
                    if (!cs_n_q && cmd == CMD_REF && banks_q == '0)
                        st_d = ST_SR;
                    else if (banks_q == '0)
                        st_d = ST_PPD;
                    else
                        st_d = ST_APD;
                end
            end
            ST_PPD, ST_APD:
            begin
                if (cke_q)
                    st_d = ST_ACT;
            end
            ST_SR:
            begin
                if (sr_exit)
                    st_d = ST_ACT;
            end
            default:
                st_d = ST_ACT;
        endcase
        if (exec)
        begin
            taken_d = 1'h1;
            case (cmd)
                CMD_ACT:
                    banks_d[ba_q] = 1'h1;
                CMD_PRE:
                begin
                    if (addr_q[AUTO_PRE_POS])
                        banks_d = '0;
                    else
                        banks_d[ba_q] = 1'h0;
                end
                CMD_LMR:
                begin
                    if (ba_q == EMR_SEL)
                        emr_term_d = addr_q[TERM_EN_POS];
                end
                CMD_WR:
                begin
                    wr_pend_d = 1'h1;
                    wr_idx_d = addr_q[IDX_W-1:0];
                end
                CMD_RD:
                begin
                    // Strobe rises with the first beat: edge aligned
                    dqr_d = mem_q[addr_q[IDX_W-1:0]][DQ_W-1:0];
                    dqf_d = mem_q[addr_q[IDX_W-1:0]][2*DQ_W-1:DQ_W];
                    dq_oe_d = 1'h1;
                    stb_d = 1'h1;
                    rstb_d = (DQ_W == X8);
                end
                default:
                    taken_d = 1'h0;
            endcase
        end
        clk_en_d = (st_d == ST_ACT);
        ib_main_d = (st_d == ST_ACT);
        ib_ct_d = (st_d != ST_SR);
        sr_flag_d = (st_d == ST_SR);
        term_on_d = term_d && emr_term_d && (st_d != ST_SR);
    end

    // ----------------------------------------------------------------
    // Link registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_true or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ST_ACT;
            {cke_q, cs_n_q, ras_q, cas_q, we_q} <= 5'h1F;
            ba_q <= '0;
            addr_q <= '0;
            term_q <= 1'h0;
            emr_term_q <= TERM_EN_RST;
            din_r_q <= '0;
            din_f_q <= '0;
            mr_q <= 2'h3;
            mf_q <= 2'h3;
            banks_q <= '0;
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= '0;
            wr_pend_q <= 1'h0;
            wr_idx_q <= '0;
            dqr_q <= '0;
            dqf_q <= '0;
            {dq_oe_q, stb_q, rstb_q, taken_q, sr_flag_q, term_on_q} <= 6'h00;
            {clk_en_q, ib_main_q, ib_ct_q} <= 3'h7;
            {comp_s1_q, comp_s2_q, x_s1_q, x_s2_q, x_s3_q} <= 5'h00;
        end
        else
        begin
            st_q <= st_d;
            {cke_q, cs_n_q, ras_q, cas_q, we_q} <= {cke_d, cs_n_d, ras_d, cas_d, we_d};
            ba_q <= ba_d;
            addr_q <= addr_d;
            term_q <= term_d;
            emr_term_q <= emr_term_d;
            din_r_q <= din_r_d;
            din_f_q <= din_f_d;
            mr_q <= mr_d;
            mf_q <= mf_d;
            banks_q <= banks_d;
            mem_q <= mem_d;
            wr_pend_q <= wr_pend_d;
            wr_idx_q <= wr_idx_d;
            dqr_q <= dqr_d;
            dqf_q <= dqf_d;
            {dq_oe_q, stb_q, rstb_q, taken_q, sr_flag_q, term_on_q} <=
                {dq_oe_d, stb_d, rstb_d, taken_d, sr_flag_d, term_on_d};
            {clk_en_q, ib_main_q, ib_ct_q} <= {clk_en_d, ib_main_d, ib_ct_d};
            // Complement should read low at each true rising edge
            comp_s1_q <= sys_clk_comp;
            comp_s2_q <= comp_s1_q;
            x_s1_q <= tgl_q;
            x_s2_q <= x_s1_q;
            x_s3_q <= x_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // Core domain: self-refresh exit survives a stopped link clock
    // ----------------------------------------------------------------
    always_comb
    begin
        pend_d = pend_q && sr_s2_q;
        tgl_d = tgl_q;
        if (sr_s2_q && cke_s2_q && !pend_q)
        begin
            tgl_d = !tgl_q;
            pend_d = 1'h1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {cke_s1_q, cke_s2_q, sr_s1_q, sr_s2_q, pend_q, tgl_q} <= 6'h00;
        end
        else
        begin
            cke_s1_q <= cke;
            cke_s2_q <= cke_s1_q;
            sr_s1_q <= sr_flag_q;
            sr_s2_q <= sr_s1_q;
            pend_q <= pend_d;
            tgl_q <= tgl_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign dq_out_rise = dqr_q;
    assign dq_out_fall = dqf_q;
    assign dq_oe = dq_oe_q;
    assign strobe_out_rise = stb_q;
    assign strobe_out_fall = 1'h0;
    assign strobe_oe = stb_q;
    assign redundant_strobe_oe = rstb_q;
    assign int_clk_en = clk_en_q;
    assign ibuf_main_en = ib_main_q;
    assign ibuf_clkterm_en = ib_ct_q;
    assign term_dq = {DQ_W{term_on_q}};
    assign term_strobe = term_on_q;
    assign term_mask = term_on_q;
    assign term_rstrobe = term_on_q && (DQ_W == X8);
    assign pwr_state = st_q;
    assign banks_open = banks_q;
    assign cmd_taken = taken_q;
    assign pair_fault = comp_s2_q;
    assign core_self_ref = sr_s2_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_rank_mask: assert property (@(posedge sys_clk_true) disable iff (rst)
        cs_n_q |=> $stable(banks_q) && !taken_q)
        else $error("command acted with rank select high");
    chk_pre_all: assert property (@(posedge sys_clk_true) disable iff (rst)
        exec && cmd == CMD_PRE && addr_q[AUTO_PRE_POS] |=> banks_q == '0)
        else $error("precharge all left a bank open");
    chk_idle_pd: assert property (@(posedge sys_clk_true) disable iff (rst)
        st_q == ST_ACT && !cke_q && banks_q == '0 && (cs_n_q || cmd != CMD_REF) |=> st_q == ST_PPD)
        else $error("idle power-down not entered");
    chk_open_pd: assert property (@(posedge sys_clk_true) disable iff (rst)
        st_q == ST_ACT && !cke_q && banks_q != '0 |=> st_q == ST_APD)
        else $error("active power-down not entered");
    chk_sr_entry: assert property (@(posedge sys_clk_true) disable iff (rst)
        $rose(st_q == ST_SR) |-> $past(!cke_q) && $past(cmd) == CMD_REF)
        else $error("self refresh entered without sampled low enable");
    chk_buf_gate: assert property (@(posedge sys_clk_true) disable iff (rst)
        st_q != ST_ACT |-> !ibuf_main_en && !int_clk_en && (ibuf_clkterm_en == (st_q != ST_SR)))
        else $error("input buffers wrong for power state");
    chk_term_gate: assert property (@(posedge sys_clk_true) disable iff (rst)
        term_strobe |-> emr_term_q && $past(term_ctrl, 1))
        else $error("termination on while disabled or not requested");
    chk_mask_keep: assert property (@(posedge sys_clk_true) disable iff (rst)
        wr_pend_q && mr_q[0] |=> mem_q[$past(wr_idx_q)][LW-1:0] == $past(mem_q[wr_idx_q][LW-1:0]))
        else $error("masked write beat changed stored lane");
    chk_read_strobe: assert property (@(posedge sys_clk_true) disable iff (rst)
        exec && cmd == CMD_RD |=> strobe_oe && strobe_out_rise && dq_oe ##1 (!strobe_oe || $past(exec && cmd == CMD_RD)))
        else $error("read strobe not aligned with read data");
    chk_sr_exit: assert property (@(posedge clk) disable iff (rst)
        sr_s2_q && cke_s2_q && !pend_q |=> tgl_q != $past(tgl_q) && pend_q)
        else $error("self refresh exit not flagged");
endmodule : sdpi_top
`default_nettype wire

// ### testbench/sdpi_ctrl_model.sv
// Memory controller model that drives the command, clock and write data pins
`timescale 1ns/1ps
`default_nettype none
module sdpi_ctrl_model
    import sdpi_pkg::*;
(
    output logic sys_clk_true,
    output logic sys_clk_comp,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [BA_W-1:0] ba,
    output logic [ADDR_W-1:0] addr,
    output logic term_ctrl,
    output logic [15:0] dq_in_rise,
    output logic [15:0] dq_in_fall,
    output logic low_byte_wmask_rise,
    output logic low_byte_wmask_fall,
    output logic up_byte_wmask_rise,
    output logic up_byte_wmask_fall
);
    logic cke_nx = 1'b1;
    logic term_nx = 1'b0;
    // ----------------------------------------------------------------
    // Link clock, unrelated in phase to the core clock
    // ----------------------------------------------------------------
    initial
    begin
        sys_clk_true = 1'b0;
        sys_clk_comp = 1'b1;
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
        {ba, addr, term_ctrl, dq_in_rise, dq_in_fall} = '0;
        {low_byte_wmask_rise, low_byte_wmask_fall, up_byte_wmask_rise, up_byte_wmask_fall} = 4'h0;
        #20;
        forever
        begin
            // Complement settles before the true edge so the pair never races
            sys_clk_comp = sys_clk_true;
            sys_clk_true = ~sys_clk_true;
            #62.5;
        end
    end
    // ----------------------------------------------------------------
    // Pin drivers, launched just after a rising link edge; beat data and masks just after the falling edge
    // ----------------------------------------------------------------
    task automatic issue(input logic sel_n, input logic [2:0] code, input logic [BA_W-1:0] b,
                         input logic [ADDR_W-1:0] a);
        @(posedge sys_clk_true);
        cke <= cke_nx;
        term_ctrl <= term_nx;
        cs_n <= sel_n;
        {ras_n, cas_n, we_n} <= code;
        ba <= b;
        addr <= a;
        // Released data lines show the inverse, not a stale value
        dq_in_rise <= ~dq_in_rise;
        dq_in_fall <= ~dq_in_fall;
    endtask : issue
    task automatic beat(input logic [15:0] r, input logic [15:0] f, input logic [3:0] m);
        issue(1'b1, 3'h7, ba, addr);
        @(negedge sys_clk_true);
        dq_in_rise = r;
        dq_in_fall = f;
        {up_byte_wmask_fall, up_byte_wmask_rise, low_byte_wmask_fall, low_byte_wmask_rise} = m;
    endtask : beat
    task automatic idle(input int n);
        repeat (n) issue(1'b1, 3'h7, ba, addr);
    endtask : idle
endmodule : sdpi_ctrl_model
`default_nettype wire

// ### testbench/sdpi_top_test.sv
// Self-checking bench of the DRAM pin interface with a controller model
`timescale 1ns/1ps
`default_nettype none
module sdpi_top_test;
    import sdpi_pkg::*;
    logic clk, rst, lclk, lclk_n, cke, cs_n, ras_n, cas_n, we_n, term_ctrl;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [15:0] dq_in_rise, dq_in_fall, dq_out_rise, dq_out_fall, term_dq;
    logic lwr, lwf, uwr, uwf, dq_oe, st_r, st_f, st_oe, rst_oe, int_clk_en, ibuf_main_en;
    logic ibuf_clkterm_en, term_strobe, term_mask, term_rstrobe, cmd_taken, pair_fault, core_self_ref;
    logic [3:0] pwr_state;
    logic [NBANK-1:0] banks_open;
    logic [31:0] mem [16];
    logic [31:0] rd_q [$];
    logic [31:0] r, f, m;
    int num_errors = 0;
    int comparisons = 0;
    int seed = 92;
    int taken_seen = 0;
    int exp_taken = 0;
    sdpi_ctrl_model ctrl (.sys_clk_true(lclk), .sys_clk_comp(lclk_n), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .term_ctrl(term_ctrl),
        .dq_in_rise(dq_in_rise), .dq_in_fall(dq_in_fall), .low_byte_wmask_rise(lwr),
        .low_byte_wmask_fall(lwf), .up_byte_wmask_rise(uwr), .up_byte_wmask_fall(uwf));
    sdpi_top #(.DQ_W(16), .DEPTH(16)) dut (.clk(clk), .rst(rst), .sys_clk_true(lclk),
        .sys_clk_comp(lclk_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .addr(addr), .term_ctrl(term_ctrl), .dq_in_rise(dq_in_rise), .dq_in_fall(dq_in_fall),
        .low_byte_wmask_rise(lwr), .low_byte_wmask_fall(lwf), .up_byte_wmask_rise(uwr),
        .up_byte_wmask_fall(uwf), .dq_out_rise(dq_out_rise), .dq_out_fall(dq_out_fall),
        .dq_oe(dq_oe), .strobe_out_rise(st_r), .strobe_out_fall(st_f), .strobe_oe(st_oe),
        .redundant_strobe_oe(rst_oe), .int_clk_en(int_clk_en), .ibuf_main_en(ibuf_main_en),
        .ibuf_clkterm_en(ibuf_clkterm_en), .term_dq(term_dq), .term_strobe(term_strobe),
        .term_mask(term_mask), .term_rstrobe(term_rstrobe), .pwr_state(pwr_state),
        .banks_open(banks_open), .cmd_taken(cmd_taken), .pair_fault(pair_fault),
        .core_self_ref(core_self_ref));
    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic end_of_test();
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic wait_state(input logic [3:0] s);
        for (int n = 0; n < 40 && pwr_state !== s; n++)
            @(negedge lclk);
        cmp(pwr_state, s);
    endtask : wait_state
    // Read data appears without notice, so an empty queue is itself a mismatch
    always @(negedge lclk)
    begin
        if (cmd_taken === 1'b1)
            taken_seen++;
        if (dq_oe === 1'b1)
        begin
            if (rd_q.size() == 0)
                cmp(32'h1, 32'h0);
            else
                cmp({dq_out_fall, dq_out_rise}, rd_q.pop_front());
            cmp({st_oe, st_r, st_f, rst_oe}, 4'hC);
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        foreach (mem[i]) mem[i] = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        ctrl.idle(2);
        ctrl.issue(1'b0, CMD_ACT, 3'h0, '0);
        exp_taken++;
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            f = $random(seed);
            m = $random(seed);
            ctrl.issue(1'b0, CMD_WR, 3'h0, ADDR_W'(i));
            ctrl.beat(r[15:0], f[15:0], m[3:0]);
            exp_taken++;
            for (int k = 0; k < 4; k++)
                if (!m[k])
                    mem[i][8*{k[0], k[1]}+:8] = {f[15:0], r[15:0]} >> (8*{k[0], k[1]});
        end
        // Deselected write and read must leave no trace
        ctrl.issue(1'b1, CMD_WR, 3'h0, '0);
        ctrl.beat(16'h5A5A, 16'hA5A5, 4'h0);
        ctrl.issue(1'b1, CMD_RD, 3'h0, 14'h1);
        ctrl.idle(2);
        for (int i = 0; i < 8; i++)
        begin
            rd_q.push_back(mem[i]);
            ctrl.issue(1'b0, CMD_RD, 3'h0, ADDR_W'(i));
            exp_taken++;
        end
        ctrl.issue(1'b0, CMD_ACT, 3'h3, '0);
        ctrl.idle(3);
        cmp(banks_open, 8'h09);
        ctrl.issue(1'b0, CMD_PRE, 3'h3, '0);
        ctrl.idle(3);
        cmp(banks_open, 8'h01);
        ctrl.issue(1'b0, CMD_PRE, 3'h5, 14'h1 << AUTO_PRE_POS);
        ctrl.idle(3);
        cmp(banks_open, 8'h00);
        exp_taken += 3;
        cmp(taken_seen, exp_taken);
        cmp(rd_q.size(), 0);
        ctrl.issue(1'b0, CMD_ACT, 3'h2, '0);
        ctrl.cke_nx = 1'b0;
        ctrl.idle(1);
        wait_state(ST_APD);
        cmp({int_clk_en, ibuf_main_en, ibuf_clkterm_en}, 3'h1);
        ctrl.issue(1'b0, CMD_RD, 3'h0, '0);
        ctrl.cke_nx = 1'b1;
        ctrl.idle(1);
        wait_state(ST_ACT);
        cmp({int_clk_en, ibuf_main_en, ibuf_clkterm_en}, 3'h7);
        ctrl.issue(1'b0, CMD_PRE, 3'h0, 14'h1 << AUTO_PRE_POS);
        ctrl.cke_nx = 1'b0;
        ctrl.idle(1);
        wait_state(ST_PPD);
        cmp({int_clk_en, ibuf_main_en, ibuf_clkterm_en}, 3'h1);
        ctrl.cke_nx = 1'b1;
        ctrl.idle(1);
        wait_state(ST_ACT);
        ctrl.term_nx = 1'b1;
        ctrl.idle(3);
        cmp({term_strobe, term_mask, term_rstrobe, &term_dq}, 4'hD);
        ctrl.cke_nx = 1'b0;
        ctrl.issue(1'b0, CMD_REF, 3'h0, '0);
        ctrl.idle(1);
        wait_state(ST_SR);
        cmp({int_clk_en, ibuf_main_en, ibuf_clkterm_en, term_strobe}, 4'h0);
        cmp(core_self_ref, 1'b1);
        ctrl.cke_nx = 1'b1;
        ctrl.idle(1);
        wait_state(ST_ACT);
        ctrl.idle(3);
        cmp({term_strobe, term_mask, term_rstrobe, &term_dq}, 4'hD);
        ctrl.issue(1'b0, CMD_LMR, EMR_SEL, '0);
        ctrl.idle(3);
        cmp({term_strobe, term_mask, |term_dq}, 3'h0);
        ctrl.issue(1'b0, CMD_LMR, EMR_SEL, 14'h1 << TERM_EN_POS);
        ctrl.idle(3);
        cmp({term_strobe, term_mask, &term_dq}, 3'h7);
        ctrl.term_nx = 1'b0;
        ctrl.idle(3);
        cmp({term_strobe, term_mask, |term_dq, pair_fault}, 4'h0);
        end_of_test();
    end
endmodule : sdpi_top_test
`default_nettype wire
